// *** uss_cfg.svh ***
// Constants and contract list for the universal serial shift/status block
//
// Contract
// - Start detector works only in two-wire mode; otherwise it is idle.
// - Data line is delayed 50 to 300 ns before sampling the clock line.
// - Start detection works without the core clock, for power-down wake; here it is sampled on ref_clk_i instead.
// - As two-wire slave, hold clock line low until ready for more data.
// - External clock pin counts both rising and falling edges.
// - Counter preloaded with F overflows on next external edge, sets flag.
// - Data register shifts left on selected external, timer or strobe.
// - Software write in same cycle as clock event wins; no shift.
// - Wire mode zero still shifts from data pin with external clock.
// - Serial output driven from data bit 7 through an output latch.
// - Latch open in first clock half if external, always if internal.
// - Transfer completion copies shift register into receive buffer.
// - Start flag set by start condition, or external clock pin edges in other modes.
// - Start flag interrupts when enabled; write one clears, releases hold.
// - Pending start interrupt wakes the processor from every sleep mode.
// - Overflow flag set on 15 to 0 wrap; write one clears, releases hold.
// - Overflow interrupt wakes the processor from idle sleep only.
// - Stop flag set on stop condition in two-wire; write one clears it.
// - Collision bit reads one in two-wire modes when data bit 7 differs from pin level.
// - Counter value is in status bits 3:0, readable and writable.
// - Counter increments once per selected clock event.
// - Mode 00 disables outputs, hold, detector; mode 01 is three-wire.
`ifndef USS_CFG_SVH
`define USS_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses (register index times four)
// ----------------------------------------------------------------------
`define USS_IDX_CTRL 8'h0D
`define USS_IDX_STATUS 8'h0E
`define USS_IDX_DATA 8'h0F
`define USS_IDX_BUFFER 8'h10
`define USS_ADDR_W 7
`define USS_ADDR_CTRL (7'(`USS_IDX_CTRL * 4))
`define USS_ADDR_STATUS (7'(`USS_IDX_STATUS * 4))
`define USS_ADDR_DATA (7'(`USS_IDX_DATA * 4))
`define USS_ADDR_BUFFER (7'(`USS_IDX_BUFFER * 4))

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define USS_CR_SIE 7
`define USS_CR_OIE 6
`define USS_CR_WM_HI 5
`define USS_CR_WM_LO 4
`define USS_CR_CS1 3
`define USS_CR_CS0 2
`define USS_CR_CLK 1
`define USS_CR_TC 0
`define USS_SR_SIF 7
`define USS_SR_OIF 6
`define USS_SR_PF 5
`define USS_SR_DC 4
`define USS_RESET_BYTE 8'h00
`define USS_CNT_MAX 4'hF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define USS_CLK_MHZ 50
`define USS_SDA_DELAY_MIN_NS 50
`define USS_SDA_DELAY_MAX_NS 300
`define USS_SDA_DELAY_CYC \
    ((`USS_SDA_DELAY_MIN_NS * `USS_CLK_MHZ + 999) / 1000)

`endif

// *** uss_pkg.sv ***
// Types for the universal serial shift/status block
package uss_pkg;
    typedef enum logic [1:0] {
        USS_WM_OFF = 2'h0,
        USS_WM_THREE = 2'h1,
        USS_WM_TWO = 2'h2,
        USS_WM_TWO_HOLD = 2'h3
    } uss_wire_mode_t;
    typedef enum logic [1:0] {
        USS_CS_SOFT = 2'h0,
        USS_CS_TIMER = 2'h1,
        USS_CS_EXT_POS = 2'h2,
        USS_CS_EXT_NEG = 2'h3
    } uss_clk_src_t;
    typedef enum logic [1:0] {
        USS_BUS_IDLE = 2'h0,
        USS_BUS_DONE = 2'h1
    } uss_bus_state_t;
endpackage

// *** uss_unit.sv ***
// Universal serial shift register, counter, start detector and status flags
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "uss_cfg.svh"
module uss_unit
    import uss_pkg::*;
#(
    parameter int SDA_DELAY_CYC = `USS_SDA_DELAY_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [6:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic timer0_match_i,
    input wire logic global_int_en_i,
    input wire logic serial_clock_pin_i,
    input wire logic serial_data_in_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n_o,
    output logic serial_data_out_o,
    output logic serial_data_oe_n_o,
    output logic start_irq_o,
    output logic overflow_irq_o,
    output logic wake_any_sleep_o,
    output logic wake_idle_o
);
    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (SDA_DELAY_CYC < 1 || SDA_DELAY_CYC >
        (`USS_SDA_DELAY_MAX_NS * `USS_CLK_MHZ) / 1000) begin : g_chk
        $error("SDA_DELAY_CYC outside the allowed delay window");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_prev_r;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_prev_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], serial_clock_pin_i};
            sda_sync_r <= {sda_sync_r[0], serial_data_in_pin_i};
            scl_prev_r <= scl_sync_r[1];
        end
    end
    logic scl_s;
    logic sda_s;
    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    logic scl_rise;
    logic scl_fall;
    assign scl_rise = scl_s & ~scl_prev_r;
    assign scl_fall = ~scl_s & scl_prev_r;

    // Delay line on the data input so the clock level is already settled
    logic [SDA_DELAY_CYC:0] sda_dly_r;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sda_dly_r <= '1;
        end else begin
            sda_dly_r <= {sda_dly_r[SDA_DELAY_CYC-1:0], sda_s};
        end
    end
    logic sda_d;
    logic sda_prev;
    assign sda_d = sda_dly_r[SDA_DELAY_CYC-1];
    assign sda_prev = sda_dly_r[SDA_DELAY_CYC];

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [7:0] ctrl_r;
    uss_wire_mode_t wm;
    uss_clk_src_t cs;
    assign wm = uss_wire_mode_t'(ctrl_r[`USS_CR_WM_HI:`USS_CR_WM_LO]);
    assign cs = uss_clk_src_t'(ctrl_r[`USS_CR_CS1:`USS_CR_CS0]);
    logic two_wire;
    assign two_wire = wm[1];

    logic wr_acc;
    logic rd_acc;
    uss_bus_state_t bus_r;
    assign wr_acc = avs_write_i && bus_r == USS_BUS_IDLE;
    assign rd_acc = avs_read_i && bus_r == USS_BUS_IDLE;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    assign wr_ctrl = wr_acc && avs_byteenable_i[0]
        && avs_address_i == `USS_ADDR_CTRL;
    assign wr_stat = wr_acc && avs_byteenable_i[0]
        && avs_address_i == `USS_ADDR_STATUS;
    assign wr_data = wr_acc && avs_byteenable_i[0]
        && avs_address_i == `USS_ADDR_DATA;
    logic [7:0] wdat;
    assign wdat = avs_writedata_i[7:0];

    // Strobe bits are write-only and act for the write cycle alone
    logic soft_clk;
    logic toggle_clk;
    assign soft_clk = wr_ctrl && wdat[`USS_CR_CLK];
    assign toggle_clk = wr_ctrl && wdat[`USS_CR_TC];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_r <= `USS_RESET_BYTE;
        end else if (wr_ctrl) begin
            ctrl_r <= {wdat[7:2], 2'h0};
        end
    end

    // ------------------------------------------------------------------
    // Clock event selection
    // ------------------------------------------------------------------
    logic ext_sel;
    assign ext_sel = ctrl_r[`USS_CR_CS1];
    logic shift_ev;
    logic count_ev;
    logic ext_edge;
    logic ext_strobe;
    // External edge of the chosen polarity clocks the data register
    assign ext_edge = (cs == USS_CS_EXT_POS) ? scl_rise : scl_fall;
    // With external source, a strobe plus clock bit counts via the pin toggle
    assign ext_strobe = toggle_clk && wdat[`USS_CR_CLK];
    always_comb begin
        shift_ev = 1'b0;
        count_ev = 1'b0;
        case (cs)
            USS_CS_SOFT: begin
                shift_ev = soft_clk;
                count_ev = soft_clk | toggle_clk;
            end
            USS_CS_TIMER: begin
                shift_ev = timer0_match_i;
                count_ev = timer0_match_i | soft_clk | toggle_clk;
            end
            default: begin
                // Inputs act regardless of wire mode
                shift_ev = ext_edge;
                // Both pin edges count
                count_ev = (scl_rise | scl_fall) | ext_strobe;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Counter, data register, buffer
    // ------------------------------------------------------------------
    logic [3:0] cnt_r;
    logic overflow_ev;
    // F preload overflows on the very next event
    assign overflow_ev = count_ev && cnt_r == `USS_CNT_MAX;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_r <= 4'h0;
        end else if (wr_stat) begin
            cnt_r <= wdat[3:0];
        end else if (count_ev) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    logic [7:0] data_r;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            data_r <= `USS_RESET_BYTE;
        end else if (wr_data) begin
            data_r <= wdat;
        end else if (shift_ev) begin
            data_r <= {data_r[6:0], sda_s};
        end
    end

    logic [7:0] buf_r;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            buf_r <= `USS_RESET_BYTE;
        end else if (overflow_ev) begin
            // Captures the byte including a shift in this same cycle
            buf_r <= (shift_ev && !wr_data)
                ? {data_r[6:0], sda_s} : data_r;
        end
    end

    // ------------------------------------------------------------------
    // Output latch: transparent with internal clock or while clock low
    // ------------------------------------------------------------------
    logic latch_r;
    logic latch_open;
    assign latch_open = !ext_sel || !scl_s;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            latch_r <= 1'b1;
        end else if (latch_open) begin
            latch_r <= wr_data ? wdat[7] : data_r[7];
        end
    end

    // ------------------------------------------------------------------
    // Start and stop detection
    // ------------------------------------------------------------------
    // The real part detects start with no clock; here it is sampled, and
    // wake_any_sleep_o exports the flag so a power controller can restart.
    logic start_cond;
    logic stop_cond;
    assign start_cond = two_wire && scl_s && sda_prev && !sda_d;
    assign stop_cond = two_wire && scl_s && !sda_prev && sda_d;
    logic start_edge_ev;
    assign start_edge_ev = !two_wire && ext_sel && !soft_clk
        && (scl_rise | scl_fall);

    logic sif_r;
    logic oif_r;
    logic pf_r;
    logic clr_sif;
    logic clr_oif;
    logic clr_pf;
    assign clr_sif = wr_stat && wdat[`USS_SR_SIF];
    assign clr_oif = wr_stat && wdat[`USS_SR_OIF];
    assign clr_pf = wr_stat && wdat[`USS_SR_PF];

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sif_r <= 1'b0;
        end else if (start_cond || start_edge_ev) begin
            sif_r <= 1'b1;
        end else if (clr_sif) begin
            sif_r <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            oif_r <= 1'b0;
        end else if (overflow_ev) begin
            oif_r <= 1'b1;
        end else if (clr_oif) begin
            oif_r <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pf_r <= 1'b0;
        end else if (stop_cond) begin
            pf_r <= 1'b1;
        end else if (clr_pf) begin
            pf_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Clock hold: start hold after the falling clock, overflow hold
    // ------------------------------------------------------------------
    logic start_hold_r;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            start_hold_r <= 1'b0;
        end else if (!two_wire || !sif_r) begin
            start_hold_r <= 1'b0;
        end else if (scl_fall) begin
            start_hold_r <= 1'b1;
        end
    end
    logic hold;
    assign hold = two_wire && (start_hold_r
        || (wm == USS_WM_TWO_HOLD && oif_r));

    // ------------------------------------------------------------------
    // Pin drivers (enable low means driving)
    // ------------------------------------------------------------------
    logic dc;
    assign dc = data_r[7] ^ sda_s;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            serial_clock_pin_o <= 1'b0;
            serial_clock_pin_oe_n_o <= 1'b1;
            serial_data_out_o <= 1'b1;
            serial_data_oe_n_o <= 1'b1;
        end else begin
            serial_clock_pin_o <= 1'b0;
            serial_clock_pin_oe_n_o <= !hold;
            serial_data_out_o <= latch_r;
            // Open drain in two-wire; direction bit is software's job
            case (wm)
                USS_WM_OFF: serial_data_oe_n_o <= 1'b1;
                USS_WM_THREE: serial_data_oe_n_o <= 1'b0;
                default: serial_data_oe_n_o <= latch_r;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt requests and wake-ups
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            start_irq_o <= 1'b0;
            overflow_irq_o <= 1'b0;
            wake_any_sleep_o <= 1'b0;
            wake_idle_o <= 1'b0;
        end else begin
            start_irq_o <= sif_r && ctrl_r[`USS_CR_SIE]
                && global_int_en_i;
            overflow_irq_o <= oif_r && ctrl_r[`USS_CR_OIE]
                && global_int_en_i;
            wake_any_sleep_o <= sif_r && ctrl_r[`USS_CR_SIE];
            wake_idle_o <= oif_r && ctrl_r[`USS_CR_OIE];
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, answer on the second edge
    // ------------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        case (avs_address_i)
            `USS_ADDR_CTRL: rd_byte = {ctrl_r[7:2], 2'h0};
            `USS_ADDR_STATUS: rd_byte = {sif_r, oif_r, pf_r,
                dc && two_wire, cnt_r};
            `USS_ADDR_DATA: rd_byte = data_r;
            `USS_ADDR_BUFFER: rd_byte = buf_r;
            default: rd_byte = 8'h00;
        endcase
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bus_r <= USS_BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
        end else begin
            case (bus_r)
                USS_BUS_IDLE: begin
                    if (rd_acc || wr_acc) begin
                        bus_r <= USS_BUS_DONE;
                        avs_waitrequest_o <= 1'b0;
                        avs_readdata_o <= {24'h0, rd_byte};
                    end
                end
                default: begin
                    bus_r <= USS_BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end
endmodule // uss_unit
`default_nettype wire

// *** uss_unit_monitor.sv ***
// Port checker for the universal serial shift/status block
`timescale 1ns/100ps
`default_nettype none
`include "uss_cfg.svh"
module uss_unit_monitor
    import uss_pkg::*;
#(
    parameter int SDA_DELAY_CYC = `USS_SDA_DELAY_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [6:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic timer0_match_i,
    input wire logic global_int_en_i,
    input wire logic serial_clock_pin_i,
    input wire logic serial_data_in_pin_i,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe_n_o,
    input wire logic serial_data_out_o,
    input wire logic serial_data_oe_n_o,
    input wire logic start_irq_o,
    input wire logic overflow_irq_o,
    input wire logic wake_any_sleep_o,
    input wire logic wake_idle_o
);
    // ----------------------------------------------------------------
    // Control shadow, taken at the same edge as the design's write
    // ----------------------------------------------------------------
    logic [7:0] ctl_r;
    logic sie_on;
    logic oie_on;
    logic rd_ans;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctl_r <= 8'h00;
        end else if (avs_write_i && avs_waitrequest_o && avs_byteenable_i[0]
                && avs_address_i == `USS_ADDR_CTRL) begin
            ctl_r <= avs_writedata_i[7:0];
        end
    end
    assign sie_on = ctl_r[7] && global_int_en_i;
    assign oie_on = ctl_r[6] && global_int_en_i;
    assign rd_ans = avs_read_i && !avs_waitrequest_o;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_answer;
        (avs_read_i || avs_write_i) && avs_waitrequest_o
            |=> !avs_waitrequest_o;
    endproperty
    property p_wait_one;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    property p_upper;
        !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000;
    endproperty
    // Strobes read back as zero, other bits as last written
    property p_ctl_rd;
        rd_ans && avs_address_i == `USS_ADDR_CTRL
            |-> avs_readdata_o[7:0] == {ctl_r[7:2], 2'b00};
    endproperty
    property p_mode_off;
        ctl_r[5:4] == USS_WM_OFF && $past(ctl_r[5:4]) == USS_WM_OFF
            |-> serial_data_oe_n_o && serial_clock_pin_oe_n_o;
    endproperty
    // Clock hold belongs to two-wire modes only
    property p_three;
        ctl_r[5:4] == USS_WM_THREE && $past(ctl_r[5:4]) == USS_WM_THREE
            |-> !serial_data_oe_n_o && serial_clock_pin_oe_n_o;
    endproperty
    property p_dc;
        rd_ans && avs_address_i == `USS_ADDR_STATUS && !ctl_r[5]
            |-> !avs_readdata_o[4];
    endproperty
    property p_sirq;
        !sie_on && $past(!sie_on) |-> !start_irq_o;
    endproperty
    property p_oirq;
        !oie_on && $past(!oie_on) |-> !overflow_irq_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no answer one cycle after take");
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low for more than one cycle");
    a_upper: assert property (p_upper)
        else $error("upper read data not zero");
    a_ctl_rd: assert property (p_ctl_rd)
        else $error("control readback wrong");
    a_mode_off: assert property (p_mode_off)
        else $error("outputs enabled in mode off");
    a_three: assert property (p_three)
        else $error("three-wire output or hold wrong");
    a_dc: assert property (p_dc)
        else $error("collision bit set outside two-wire");
    a_sirq: assert property (p_sirq)
        else $error("start interrupt while disabled");
    a_oirq: assert property (p_oirq)
        else $error("overflow interrupt while disabled");
    c_sirq: cover property ($rose(start_irq_o));
    c_oirq: cover property ($rose(overflow_irq_o));
    c_hold: cover property ($fell(serial_clock_pin_oe_n_o));
endmodule // uss_unit_monitor
`default_nettype wire

// *** uss_serial_peer.sv ***
// Serial bus master model driving the clock and data lines
`timescale 1ns/100ps
`default_nettype none
module uss_serial_peer #(
    parameter int HALF_NS = 80,
    parameter int SKEW_NS = 3
) (
    output logic scl_o,
    output logic sda_o
);
    // Idle high, as with pull-ups; half period keeps the rate low
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic set_scl(input logic v);
        #(SKEW_NS + HALF_NS) scl_o = v;
    endtask
    // Data moves mid-low phase, so it never changes near a clock edge
    task automatic send_byte(input logic [7:0] b);
        #(SKEW_NS);
        for (int i = 7; i >= 0; i--) begin
            #(HALF_NS / 2) scl_o = 1'b0;
            #(HALF_NS / 2) sda_o = b[i];
            #(HALF_NS / 2) scl_o = 1'b1;
            #(HALF_NS / 2);
        end
    endtask
    task automatic start_cond;
        #(SKEW_NS + HALF_NS) sda_o = 1'b0;
        #(HALF_NS) scl_o = 1'b0;
    endtask
    task automatic stop_cond;
        #(SKEW_NS + HALF_NS) sda_o = 1'b0;
        #(HALF_NS) scl_o = 1'b1;
        #(HALF_NS) sda_o = 1'b1;
    endtask
endmodule // uss_serial_peer
`default_nettype wire

// *** universal_serial_shift_status_tb_top.sv ***
// Testbench top for the universal serial shift/status block
`timescale 1ns/100ps
`default_nettype none
`include "uss_cfg.svh"
module universal_serial_shift_status_tb_top;
    localparam logic [6:0] A_CT = `USS_ADDR_CTRL;
    localparam logic [6:0] A_ST = `USS_ADDR_STATUS;
    localparam logic [6:0] A_DA = `USS_ADDR_DATA;
    localparam logic [6:0] A_BU = `USS_ADDR_BUFFER;
    logic clk, rst, rd, wr, tmr, gie, two_wire, wreq;
    logic [6:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, sirq, oirq, wk_any, wk_idle;
    logic p_scl, p_sda, scl_w, sda_w;
    logic [7:0] q;
    int bad_count = 0;
    int n_checks = 0;
    // Open-drain wires; in three-wire mode the output has its own pin
    assign scl_w = p_scl & (scl_oe_n | scl_o);
    assign sda_w = p_sda & (!two_wire | sda_oe_n | sda_o);
    uss_unit #(.SDA_DELAY_CYC(3)) i_uss_unit (
        .ref_clk_i(clk), .rst_i(rst), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .timer0_match_i(tmr),
        .global_int_en_i(gie), .serial_clock_pin_i(scl_w),
        .serial_data_in_pin_i(sda_w), .serial_clock_pin_o(scl_o),
        .serial_clock_pin_oe_n_o(scl_oe_n), .serial_data_out_o(sda_o),
        .serial_data_oe_n_o(sda_oe_n), .start_irq_o(sirq),
        .overflow_irq_o(oirq), .wake_any_sleep_o(wk_any),
        .wake_idle_o(wk_idle));
    uss_serial_peer i_uss_serial_peer (.scl_o(p_scl), .sda_o(p_sda));
    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Timer pulse t rides with the request, so it lands at the take edge
    task automatic bus(input logic w, input logic [6:0] a,
            input logic [7:0] d, input logic t);
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h000000, d};
        be <= 4'hF;
        tmr <= t;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
            tmr <= 1'b0;
        end while (wreq !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 1'b0);
        check(q, e);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (8000) @(posedge clk);
        bad_count++;
        test_done;
    end
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, rd, wr, tmr, gie, two_wire} = 6'b100000;
        addr = 7'h00;
        wdata = 32'h00000000;
        be = 4'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk(A_ST, 8'h00);
        rchk(A_CT, 8'h00);
        rchk(7'h00, 8'h00);
        wreg(A_ST, 8'h0A);
        rchk(A_ST, 8'h0A);
        gie <= 1'b1;
        wreg(A_CT, 8'h10);
        wreg(A_ST, 8'h00);
        wreg(A_DA, 8'h81);
        wreg(A_CT, 8'h12);
        rchk(A_DA, 8'h03);
        rchk(A_ST, 8'h01);
        check({7'h00, sda_oe_n}, 8'h00);
        wreg(A_DA, 8'h80);
        repeat (2) @(posedge clk);
        check({7'h00, sda_o}, 8'h01);
        wreg(A_ST, 8'h0F);
        wreg(A_CT, 8'h52);
        rchk(A_ST, 8'h40);
        check({6'h00, oirq, wk_idle}, 8'h03);
        check({7'h00, wk_any}, 8'h00);
        rchk(A_BU, 8'h01);
        wreg(A_ST, 8'h00);
        rchk(A_ST, 8'h40);
        wreg(A_ST, 8'h40);
        rchk(A_ST, 8'h00);
        check({7'h00, oirq}, 8'h00);
        wreg(A_CT, 8'h14);
        bus(1'b1, A_DA, 8'h3C, 1'b1);
        rchk(A_DA, 8'h3C);
        tmr <= 1'b1;
        @(posedge clk);
        tmr <= 1'b0;
        rchk(A_DA, 8'h79);
        wreg(A_CT, 8'h08);
        wreg(A_ST, 8'hE0);
        i_uss_serial_peer.send_byte(8'hC3);
        repeat (8) @(posedge clk);
        rchk(A_DA, 8'hC3);
        rchk(A_BU, 8'hC3);
        rchk(A_ST, 8'hC0);
        wreg(A_ST, 8'hCF);
        i_uss_serial_peer.set_scl(1'b0);
        repeat (8) @(posedge clk);
        rchk(A_ST, 8'hC0);
        i_uss_serial_peer.set_scl(1'b1);
        wreg(A_CT, 8'h10);
        wreg(A_ST, 8'hE0);
        i_uss_serial_peer.start_cond;
        i_uss_serial_peer.stop_cond;
        repeat (8) @(posedge clk);
        rchk(A_ST, 8'h00);
        wreg(A_DA, 8'hFF);
        two_wire <= 1'b1;
        wreg(A_CT, 8'hA8);
        wreg(A_ST, 8'hE0);
        i_uss_serial_peer.start_cond;
        repeat (8) @(posedge clk);
        rchk(A_ST, 8'h91);
        check({6'h00, sirq, wk_any}, 8'h03);
        check({6'h00, scl_o, scl_oe_n}, 8'h00);
        wreg(A_ST, 8'h80);
        repeat (3) @(posedge clk);
        check({7'h00, scl_oe_n}, 8'h01);
        i_uss_serial_peer.stop_cond;
        repeat (8) @(posedge clk);
        rchk(A_ST, 8'h21);
        wreg(A_ST, 8'h20);
        rchk(A_ST, 8'h00);
        test_done;
    end
endmodule // universal_serial_shift_status_tb_top
bind uss_unit uss_unit_monitor #(.SDA_DELAY_CYC(SDA_DELAY_CYC)) i_mon (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .timer0_match_i(timer0_match_i), .global_int_en_i(global_int_en_i),
    .serial_clock_pin_i(serial_clock_pin_i),
    .serial_data_in_pin_i(serial_data_in_pin_i),
    .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe_n_o(serial_clock_pin_oe_n_o),
    .serial_data_out_o(serial_data_out_o),
    .serial_data_oe_n_o(serial_data_oe_n_o), .start_irq_o(start_irq_o),
    .overflow_irq_o(overflow_irq_o), .wake_any_sleep_o(wake_any_sleep_o),
    .wake_idle_o(wake_idle_o));
`default_nettype wire
